/* core/spb_burst_counter.sv */
// Burst address sequencer for the two low address bits.
// Assumes the caller holds the start value and the step count in its own state.
`timescale 1ns/1ps
module spb_burst_counter (
	input wire logic [1:0] start_in,
	input wire logic [1:0] count_in,
	input wire logic order_in,
	output logic [1:0] cur_low_out,
	output logic [1:0] next_low_out,
	output logic [1:0] next_count_out
);
	import spb_pkg::*;

	// ----------------------------------------
	// Order function
	// ----------------------------------------
	// The count wraps modulo four, so the fifth address equals the first.
	function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] count,
		input logic interleaved);
		if (interleaved) begin
			burst_low = start ^ count;
		end else begin
			burst_low = 2'(start + count);
		end
	endfunction

	always_comb begin
		next_count_out = 2'(count_in + 2'h1);
		cur_low_out = burst_low(start_in, count_in, order_in);
		next_low_out = burst_low(start_in, next_count_out, order_in);
	end

endmodule

/* core/spb_sram_ctrl.sv */
// Control core of a synchronous pipelined burst memory with flip-flop storage.
// Assumes the far side keeps strobes off while waking and manages output enable on turnaround.
`timescale 1ns/1ps
module spb_sram_ctrl #(
	parameter int ADDR_W = spb_pkg::ADDR_W
) (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [ADDR_W-1:0] address_in,
	input wire spb_pkg::spb_chip_en_t chip_en_in,
	input wire spb_pkg::spb_ctrl_t ctrl_in,
	input wire logic output_enable_n_in,
	input wire logic burst_order_select_in,
	input wire logic sleep_request_in,
	input wire spb_pkg::spb_word_t data_in,
	output spb_pkg::spb_word_t data_out,
	output logic data_oe_n_out,
	output logic powered_down_out
);
	import spb_pkg::*;

	if (ADDR_W < 3 || ADDR_W > 24) begin : g_bad_width
		$error("ADDR_W must lie between 3 and 24");
	end

	localparam int DEPTH = 1 << ADDR_W;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:2] addr_hi;
		logic [1:0] start;
		logic [1:0] count;
		logic active;
		logic rd_flag;
		logic valid1;
		spb_word_t stage1;
		logic valid2;
		spb_word_t stage2;
		logic wr_off;
		logic asleep;
		logic [1:0] wake;
		spb_op_t op;
	} spb_state_t;

	spb_state_t st;
	spb_state_t next_st;
	// The array stays outside the state record; copying it every cycle would cost too much.
	spb_word_t rd_word;
	logic mem_we;
	logic [ADDR_W-1:0] mem_waddr;
	logic [LANES-1:0] mem_wmask;
	logic [1:0] cur_low;
	logic [1:0] nxt_low;
	logic [1:0] nxt_count;
	logic [LANES-1:0] lane_mask;
	logic selected;
	logic proc_start;
	logic is_write;
	logic run;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	spb_burst_counter u_counter (
		.start_in(st.start),
		.count_in(st.count),
		.order_in(burst_order_select_in),
		.cur_low_out(cur_low),
		.next_low_out(nxt_low),
		.next_count_out(nxt_count)
	);

	spb_write_decode u_wdec (
		.global_write_n_in(ctrl_in.global_write_n),
		.byte_write_gate_n_in(ctrl_in.byte_write_gate_n),
		.lane_write_enable_n_in(ctrl_in.lane_write_enable_n),
		.lane_mask_out(lane_mask)
	);

	assign selected = !chip_en_in.primary_chip_enable_n && chip_en_in.secondary_chip_enable &&
		!chip_en_in.secondary_chip_enable_n;
	assign proc_start = !ctrl_in.proc_address_strobe_n &&
		!chip_en_in.primary_chip_enable_n;
	assign is_write = |lane_mask;
	assign run = !sleep_request_in && (st.wake == 2'h0);

	// ----------------------------------------
	// Cycle decode
	// ----------------------------------------
	always_comb begin
		next_st = st;
		mem_we = 1'b0;
		mem_waddr = {st.addr_hi, cur_low};
		mem_wmask = lane_mask;
		if (sleep_request_in) begin
			// Everything holds; only the asleep flag is set and the wake timer armed.
			next_st.asleep = 1'b1;
			next_st.wake = WAKE_COUNT;
		end else if (st.wake != 2'h0) begin
			next_st.asleep = 1'b0;
			next_st.wake = 2'(st.wake - 2'h1);
		end else begin
			next_st.valid1 = st.rd_flag;
			next_st.stage1 = rd_word;
			next_st.valid2 = st.valid1;
			next_st.stage2 = st.stage1;
			next_st.wr_off = 1'b0;
			next_st.rd_flag = 1'b0;
			next_st.op = SPB_OP_IDLE;
			if (proc_start || !ctrl_in.ctrl_address_strobe_n) begin
				if (!selected) begin
					// Deselect drops the burst and blanks the pins one cycle later.
					next_st.op = SPB_OP_DESELECT;
					next_st.active = 1'b0;
					next_st.valid1 = 1'b0;
					next_st.valid2 = 1'b0;
				end else begin
					next_st.addr_hi = address_in[ADDR_W-1:2];
					next_st.start = address_in[1:0];
					next_st.count = COUNT_RESET;
					next_st.active = 1'b1;
					if (!proc_start && is_write) begin
						// Controller strobe samples the lanes on this very edge.
						next_st.op = SPB_OP_BEGIN_WRITE;
						mem_we = 1'b1;
						mem_waddr = address_in;
						next_st.wr_off = 1'b1;
					end else begin
						// Processor strobe ignores advance and lane enables here.
						next_st.op = SPB_OP_BEGIN_READ;
						next_st.rd_flag = 1'b1;
					end
				end
			end else if (st.active) begin
				if (!ctrl_in.burst_advance_n) begin
					next_st.op = SPB_OP_CONTINUE;
					next_st.count = nxt_count;
					mem_waddr = {st.addr_hi, nxt_low};
				end else begin
					next_st.op = SPB_OP_SUSPEND;
				end
				if (is_write) begin
					mem_we = 1'b1;
					next_st.wr_off = 1'b1;
				end else begin
					next_st.rd_flag = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Array and pins
	// ----------------------------------------
	for (genvar l = 0; l < LANES; l++) begin : g_mem_lane
		// One store per lane, so a byte write cannot disturb its neighbour.
		spb_lane_t lane_mem [DEPTH];
		always_ff @(posedge clk_sys_in) begin
			if (mem_we && mem_wmask[l]) begin
				lane_mem[mem_waddr] <= data_in[l];
			end
		end
		assign rd_word[l] = lane_mem[{st.addr_hi, cur_low}];
	end

	assign data_out = st.stage2;
	// Sleep and output enable act at once, without waiting for an edge.
	assign data_oe_n_out = !(st.valid2 && !st.wr_off && !output_enable_n_in &&
		!sleep_request_in);
	assign powered_down_out = st.asleep || sleep_request_in;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);

	chk_sleep_hiz: assert property (
		sleep_request_in |-> data_oe_n_out)
		else $error("pins driven during sleep");

	chk_sleep_hold: assert property (
		sleep_request_in |=> $stable(st.count) && $stable(st.addr_hi) &&
		$stable(st.stage2) && $stable(st.active))
		else $error("state changed during sleep");

	chk_wake_load: assert property (
		$fell(sleep_request_in) |-> st.asleep && st.wake == WAKE_COUNT)
		else $error("wake timer not armed by sleep");

	chk_wake_delay: assert property (
		(sleep_request_in ##1 !sleep_request_in[*2])
		|-> $stable(st.count) && $stable(st.active) && st.wake != 2'h0)
		else $error("block resumed before wake-up ended");

	chk_proc_load: assert property (
		run && proc_start && selected |=> st.rd_flag && !st.wr_off && st.count == 2'h0 &&
		st.addr_hi == $past(address_in[ADDR_W-1:2]))
		else $error("processor strobe did not begin a read");

	// A strobe on either edge may deselect and drop the read, so both edges stay quiet.
	chk_read_pipe: assert property (
		run && st.rd_flag && !proc_start && ctrl_in.ctrl_address_strobe_n ##1
		run && !proc_start && ctrl_in.ctrl_address_strobe_n
		|=> st.valid2 && st.stage2 == $past(st.stage1))
		else $error("read data not through two stages");

	chk_adv_ignored: assert property (
		run && proc_start && selected && !ctrl_in.burst_advance_n
		|=> st.count == 2'h0 && st.op == SPB_OP_BEGIN_READ)
		else $error("advance acted on a processor strobe edge");

	chk_lanes_ignored: assert property (
		run && proc_start && selected && is_write
		|=> !st.wr_off && st.op == SPB_OP_BEGIN_READ)
		else $error("write began on a processor strobe edge");

	chk_read_step: assert property (
		run && st.active && !proc_start && ctrl_in.ctrl_address_strobe_n &&
		!ctrl_in.burst_advance_n && !is_write
		|=> st.rd_flag && st.count == 2'($past(st.count) + 2'h1))
		else $error("read burst did not step");

	chk_write_step: assert property (
		run && st.active && !proc_start && ctrl_in.ctrl_address_strobe_n &&
		!ctrl_in.burst_advance_n && is_write
		|=> st.wr_off && st.count == 2'($past(st.count) + 2'h1))
		else $error("write burst did not step");

	chk_burst_step: assert property (
		run && st.active && !proc_start && ctrl_in.ctrl_address_strobe_n &&
		!ctrl_in.burst_advance_n
		|=> st.count == 2'($past(st.count) + 2'h1))
		else $error("burst did not advance");

	chk_burst_hold: assert property (
		run && st.active && !proc_start && ctrl_in.ctrl_address_strobe_n &&
		ctrl_in.burst_advance_n
		|=> $stable(st.count) && st.op == SPB_OP_SUSPEND)
		else $error("suspend moved the burst");

	chk_ctrl_lanes: assert property (
		run && !ctrl_in.ctrl_address_strobe_n && proc_start && selected
		|=> !st.wr_off && st.op == SPB_OP_BEGIN_READ)
		else $error("controller strobe started a write beside a processor strobe");

	chk_ctrl_write: assert property (
		run && !proc_start && !ctrl_in.ctrl_address_strobe_n && selected && is_write
		|=> st.wr_off && data_oe_n_out && st.op == SPB_OP_BEGIN_WRITE)
		else $error("controller write start missed");

	chk_proc_blocked: assert property (
		run && !ctrl_in.proc_address_strobe_n && chip_en_in.primary_chip_enable_n &&
		ctrl_in.ctrl_address_strobe_n
		|=> st.op inside {SPB_OP_IDLE, SPB_OP_CONTINUE, SPB_OP_SUSPEND})
		else $error("processor strobe acted with primary enable off");

	chk_full_write: assert property (
		!ctrl_in.global_write_n |-> &lane_mask)
		else $error("global write missed a lane");

	chk_no_write: assert property (
		ctrl_in.global_write_n && ctrl_in.byte_write_gate_n |-> lane_mask == '0)
		else $error("write decoded with the gate off");

	chk_lane_select: assert property (
		ctrl_in.global_write_n && !ctrl_in.byte_write_gate_n
		|-> lane_mask == ~ctrl_in.lane_write_enable_n)
		else $error("byte lanes decoded wrongly");

	chk_write_off: assert property (
		st.wr_off |-> data_oe_n_out)
		else $error("pins driven in a write cycle");

	chk_cont_write: assert property (
		run && st.active && !proc_start && ctrl_in.ctrl_address_strobe_n && is_write
		|-> mem_we && mem_waddr[ADDR_W-1:2] == st.addr_hi)
		else $error("burst write missed the array");

	chk_wrap: assert property (
		run && st.active && st.count == 2'h3 && !proc_start &&
		ctrl_in.ctrl_address_strobe_n && !ctrl_in.burst_advance_n
		|=> st.count == 2'h0)
		else $error("burst counter did not wrap");

	chk_linear_order: assert property (
		!burst_order_select_in |-> cur_low == 2'(st.start + st.count))
		else $error("linear burst order wrong");

	chk_interleave_order: assert property (
		burst_order_select_in |-> cur_low == (st.start ^ st.count))
		else $error("interleaved burst order wrong");

	chk_deselect: assert property (
		run && (proc_start || !ctrl_in.ctrl_address_strobe_n) && !selected
		|=> !st.active && data_oe_n_out)
		else $error("deselect left the pins driven");

	chk_oe_async: assert property (
		output_enable_n_in |-> data_oe_n_out)
		else $error("pins driven with output enable off");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	cov_read_out: cover property (st.op == SPB_OP_BEGIN_READ ##2 !data_oe_n_out);
	cov_write: cover property (st.op == SPB_OP_BEGIN_WRITE ##2 st.op == SPB_OP_CONTINUE);
	cov_wrap: cover property (st.count == 2'h3 ##1 st.count == 2'h0 && st.active);
	cov_wake: cover property (sleep_request_in ##1 !sleep_request_in[*3]);

endmodule

/* core/spb_write_decode.sv */
// Write decoder: turns the global write, gate and lane enables into a lane mask.
// Assumes the enables are sampled by the caller on the rising edge.
`timescale 1ns/1ps
module spb_write_decode (
	input wire logic global_write_n_in,
	input wire logic byte_write_gate_n_in,
	input wire logic [spb_pkg::LANES-1:0] lane_write_enable_n_in,
	output logic [spb_pkg::LANES-1:0] lane_mask_out
);
	import spb_pkg::*;

	// ----------------------------------------
	// Per-lane decode
	// ----------------------------------------
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		// Global write covers every lane; otherwise the gate qualifies each lane enable.
		assign lane_mask_out[l] = !global_write_n_in ||
			(!byte_write_gate_n_in && !lane_write_enable_n_in[l]);
	end

endmodule

/* shared/spb_pkg.sv */
// Shared types and constants of the pipelined burst memory block.
// Assumes a single synchronous clock; sleep and output enable act without it, burst order only on its edges.
package spb_pkg;

	// ----------------------------------------
	// Sizes and counts
	// ----------------------------------------
	localparam int ADDR_W = 17;
	localparam int LANES = 2;
	localparam int LANE_BITS = 8;
	localparam int BURST_LEN = 4;
	localparam int WAKE_CYCLES = 2;
	localparam logic [1:0] WAKE_COUNT = 2'(WAKE_CYCLES);
	localparam logic [1:0] COUNT_RESET = 2'h0;

	// ----------------------------------------
	// Pin groups
	// ----------------------------------------
	typedef struct packed {
		logic parity;
		logic [LANE_BITS-1:0] data;
	} spb_lane_t;

	// Lane b sits above lane a.
	typedef spb_lane_t [LANES-1:0] spb_word_t;

	typedef struct packed {
		logic primary_chip_enable_n;
		logic secondary_chip_enable;
		logic secondary_chip_enable_n;
	} spb_chip_en_t;

	typedef struct packed {
		logic proc_address_strobe_n;
		logic ctrl_address_strobe_n;
		logic burst_advance_n;
		logic global_write_n;
		logic byte_write_gate_n;
		logic [LANES-1:0] lane_write_enable_n;
	} spb_ctrl_t;

	typedef enum logic [2:0] {
		SPB_OP_IDLE,
		SPB_OP_DESELECT,
		SPB_OP_BEGIN_READ,
		SPB_OP_BEGIN_WRITE,
		SPB_OP_CONTINUE,
		SPB_OP_SUSPEND
	} spb_op_t;

endpackage

/* verification/spb_bus_model.sv */
// Far-side model of the shared data pins between the memory and its host.
// Assumes the host drives host_data_in only while host_drive_in is high.
`timescale 1ns/1ps
module spb_bus_model (
	input wire logic clk_sys_in,
	input wire spb_pkg::spb_word_t dev_data_in,
	input wire logic dev_oe_n_in,
	input wire spb_pkg::spb_word_t host_data_in,
	input wire logic host_drive_in,
	output spb_pkg::spb_word_t bus_out,
	output logic clash_out
);
	import spb_pkg::*;
	spb_word_t last = '0;
	// A released bus shows the inverse of its last value, so stale data never matches.
	always_comb begin
		if (!dev_oe_n_in)
			bus_out = dev_data_in;
		else if (host_drive_in)
			bus_out = host_data_in;
		else
			bus_out = ~last;
	end
	assign clash_out = !dev_oe_n_in && host_drive_in;
	always_ff @(posedge clk_sys_in) begin
		last <= bus_out;
	end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the pipelined burst memory control core.
// Assumes the bus model resolves the data pins; inputs change on the falling edge.
`timescale 1ns/1ps
module testbench;
	import spb_pkg::*;
	localparam int AW = 6;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic clk_sys_in = 0, sys_rst_in = 1, oe_n = 1, burst_order_select = 0, zz = 0;
	logic [AW-1:0] address_in = '0;
	spb_chip_en_t chip_en_in = 3'h2;
	spb_ctrl_t ctrl_in = '1;
	spb_word_t data_in, data_out, host_data = '0;
	logic data_oe_n_out, powered_down_out, host_drive = 0, clash;
	spb_word_t exp_mem [2**AW];
	spb_word_t exp_q [$];
	int err_count = 0, check_count = 0, seed = 57;
	always #5 clk_sys_in = ~clk_sys_in;
	spb_sram_ctrl #(.ADDR_W(AW)) dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.address_in(address_in), .chip_en_in(chip_en_in), .ctrl_in(ctrl_in),
		.output_enable_n_in(oe_n), .burst_order_select_in(burst_order_select), .sleep_request_in(zz),
		.data_in(data_in), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
		.powered_down_out(powered_down_out));
	spb_bus_model bus_u (.clk_sys_in(clk_sys_in), .dev_data_in(data_out),
		.dev_oe_n_in(data_oe_n_out), .host_data_in(host_data),
		.host_drive_in(host_drive), .bus_out(data_in), .clash_out(clash));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [AW-1:0] seq(input logic [AW-1:0] a, input int n, input logic o);
		logic [1:0] lo;
		lo = o ? (a[1:0] ^ 2'(n)) : (a[1:0] + 2'(n));
		return {a[AW-1:2], lo};
	endfunction
	// Edge 0 writes junk, edge 1 suspends and overwrites it, edges 2 to 4 continue.
	task automatic wr_burst(input logic [AW-1:0] a);
		spb_word_t d;
		for (int i = 0; i < 6; i++) begin
			@(negedge clk_sys_in);
			if (i > 0) check("write drivers", 1, data_oe_n_out);
			d = spb_word_t'($random(seed));
			ctrl_in = '1;
			oe_n = (i == 0 || i == 5);
			host_drive = (i < 5);
			host_data = d;
			address_in = a;
			ctrl_in.global_write_n = (i == 5);
			ctrl_in.ctrl_address_strobe_n = (i != 0);
			ctrl_in.burst_advance_n = (i < 2);
			if (i > 0 && i < 5) exp_mem[seq(a, i - 1, 0)] = d;
		end
	endtask
	// Write decode and advance are low on the start edge; both must be ignored.
	task automatic rd_burst(input logic [AW-1:0] a, input logic o);
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_sys_in);
			ctrl_in = '1;
			burst_order_select = o;
			ctrl_in.burst_advance_n = (i > 4);
			if (i == 0) begin
				address_in = a;
				ctrl_in = '0;
				ctrl_in.proc_address_strobe_n = 0;
			end
			oe_n = (i < 3 || i == 7);
			if (i >= 3 && i < 7) exp_q.push_back(exp_mem[seq(a, i - 3, o)]);
		end
	endtask
	task automatic bw_one(input logic [AW-1:0] a, input logic [1:0] we, input logic gate);
		spb_word_t d;
		@(negedge clk_sys_in);
		ctrl_in = '1;
		ctrl_in.ctrl_address_strobe_n = 0;
		chip_en_in.secondary_chip_enable = 0;
		@(negedge clk_sys_in);
		d = spb_word_t'($random(seed));
		chip_en_in.secondary_chip_enable = 1;
		address_in = a;
		host_data = d;
		host_drive = 1;
		oe_n = 0;
		ctrl_in.byte_write_gate_n = gate;
		ctrl_in.lane_write_enable_n = we;
		for (int j = 0; j < LANES; j++)
			if (!gate && !we[j]) exp_mem[a][j] = d[j];
		@(negedge clk_sys_in);
		check("lane write drivers", 1, data_oe_n_out);
		oe_n = 1;
		host_drive = 0;
		ctrl_in = '1;
	endtask
	// ----------------------------------------
	// Result watcher, watchdog and sequence
	// ----------------------------------------
	always @(posedge clk_sys_in) begin
		if (!sys_rst_in) begin
			check("bus clash", 0, clash);
			if (data_oe_n_out === 1'b0) begin
				if (exp_q.size() == 0)
					check("unexpected drive", 1, 0);
				else
					check("read data", exp_q.pop_front(), data_in);
			end
		end
	end
	initial begin
		#100000;
		err_count++;
		test_done();
	end
	initial begin
		logic [AW-1:0] a;
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		sys_rst_in = 0;
		a = AW'($random(seed));
		wr_burst(a);
		for (int r = 0; r < 4; r++)
			rd_burst({a[AW-1:2], 2'(r)}, r[0]);
		bw_one(a, 2'b10, 0);
		bw_one(a, 2'b01, 0);
		bw_one(a, 2'b00, 1);
		rd_burst(a, 0);
		for (int k = 0; k < 3; k++) begin
			@(negedge clk_sys_in);
			chip_en_in = spb_chip_en_t'(3'h2 ^ (3'h1 << k));
			ctrl_in.proc_address_strobe_n = 0;
			repeat (3) begin
				@(negedge clk_sys_in);
				check("deselected pins", 1, data_oe_n_out);
				oe_n = 0;
			end
		end
		@(negedge clk_sys_in);
		chip_en_in = 3'h2;
		oe_n = 1;
		ctrl_in = '1;
		zz = 1;
		repeat (3) begin
			@(negedge clk_sys_in);
			check("sleep flag", 1, powered_down_out);
			check("sleep pins", 1, data_oe_n_out);
			oe_n = 0;
			host_drive = 1;
			ctrl_in.ctrl_address_strobe_n = 0;
			ctrl_in.global_write_n = 0;
		end
		@(negedge clk_sys_in);
		zz = 0;
		oe_n = 1;
		host_drive = 0;
		ctrl_in = '1;
		repeat (2) @(negedge clk_sys_in);
		rd_burst(a, 0);
		repeat (4) @(negedge clk_sys_in);
		check("pending reads", 0, exp_q.size());
		test_done();
	end
endmodule
